// ### wrg_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrg_cfg.svh"

module wrg_guard #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 32,
	parameter int CNT_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic req_last_in,
	input wire logic req_local_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [DATA_W-1:0] rsp_rdata_out,
	output logic [ADDR_W-1:0] dev_addr_out,
	output logic dev_wr_out,
	output logic dev_rd_out,
	output logic [DATA_W-1:0] dev_data_out,
	output logic dev_data_oe_out,
	input wire logic [DATA_W-1:0] dev_data_in
);

	// saturation point of the elapsed counter and the last beat of the read strobe
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(`WRG_RD_HOLD_CYC - `WRG_ONE);

	// sequencer and request capture; every pin output is one of these registers
	wrg_pkg::wrg_state_t state_reg, state_next;
	logic ready_reg, ready_next;
	logic rvalid_reg, rvalid_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic wr_reg, wr_next;
	logic rd_reg, rd_next;
	logic oe_reg, oe_next;
	logic last_reg, last_next;
	logic local_reg, local_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	// write history: target, fifo flag, cycles since its strobe ended
	logic hist_valid_reg, hist_valid_next;
	logic [ADDR_W-1:0] hist_addr_reg, hist_addr_next;
	logic hist_fifo_reg, hist_fifo_next;
	logic [CNT_W-1:0] elapsed_reg, elapsed_next;
	// device data comes from pins, so two stages before use
	logic [DATA_W-1:0] sync1_reg;
	logic [DATA_W-1:0] sync2_reg;
	// wait asked by the pair table and the permission to launch a read
	logic [CNT_W-1:0] need;
	logic go;

	// pair table: last write target and pending read target give a cycle count
	wrg_wait_table #(
		.ADDR_W(ADDR_W),
		.CNT_W(CNT_W)
	) u_table (
		.wr_addr_in(hist_addr_reg),
		.wr_fifo_in(hist_fifo_reg),
		.rd_addr_in(addr_reg),
		.need_out(need)
	);

	// read may start once no relevant write is pending or its time has run out
	assign go = !hist_valid_reg || local_reg || (elapsed_reg >= need);

	// sequencer next-state; every device cycle goes through here so spacing is enforced in hardware
	always_comb begin
		// strobes default low, so each lasts one cycle unless a state raises it again
		state_next = state_reg;
		ready_next = ready_reg;
		rvalid_next = 1'b0;
		rdata_next = rdata_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		oe_next = 1'b0;
		last_next = last_reg;
		local_next = local_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			wrg_pkg::WRG_ST_IDLE: begin
				// capture the whole request so the pins stay steady through the access
				if (req_valid_in && ready_reg) begin
					ready_next = 1'b0;
					addr_next = req_addr_in;
					wdata_next = req_wdata_in;
					last_next = req_last_in;
					local_next = req_local_in;
					if (req_write_in) begin
						wr_next = 1'b1;
						oe_next = 1'b1;
						state_next = wrg_pkg::WRG_ST_WRITE;
					end else begin
						state_next = wrg_pkg::WRG_ST_HOLD;
					end
				end
			end
			wrg_pkg::WRG_ST_WRITE: begin
				// one-cycle strobe; the device takes address and data on it
				ready_next = 1'b1;
				state_next = wrg_pkg::WRG_ST_IDLE;
			end
			wrg_pkg::WRG_ST_HOLD: begin
				// a parked read costs at least this one cycle, so one-cycle waits come free
				if (go) begin
					rd_next = 1'b1;
					cnt_next = CNT_W'(`WRG_CNT_ZERO);
					state_next = wrg_pkg::WRG_ST_READ;
				end
			end
			wrg_pkg::WRG_ST_READ: begin
				// data was caught in the first strobe cycle and has passed both stages by now
				if (cnt_reg == RD_LAST) begin
					rdata_next = sync2_reg;
					rvalid_next = 1'b1;
					ready_next = 1'b1;
					state_next = wrg_pkg::WRG_ST_IDLE;
				end else begin
					// keep the strobe up for the remaining beats
					rd_next = 1'b1;
					cnt_next = cnt_reg + CNT_W'(`WRG_ONE);
				end
			end
		endcase
	end

	// history next-state; elapsed time counts every kind of traffic, dummy reads included
	always_comb begin
		hist_valid_next = hist_valid_reg;
		hist_addr_next = hist_addr_reg;
		hist_fifo_next = hist_fifo_reg;
		// saturating, so a long quiet spell never wraps back into a false short wait
		elapsed_next = (elapsed_reg == CNT_MAX) ? elapsed_reg : elapsed_reg + CNT_W'(`WRG_ONE);
		// only the piece that completes the word, on a core register, restarts the clock
		if (state_reg == wrg_pkg::WRG_ST_WRITE && last_reg && !local_reg) begin
			hist_valid_next = 1'b1;
			hist_addr_next = addr_reg;
			hist_fifo_next = (addr_reg >= ADDR_W'(`WRG_A_FIFO_LO)) && (addr_reg <= ADDR_W'(`WRG_A_FIFO_HI));
			elapsed_next = CNT_W'(`WRG_CNT_ZERO);
		end
	end

	// state registers; clock enable low freezes everything
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= wrg_pkg::WRG_ST_IDLE;
			ready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			oe_reg <= 1'b0;
			last_reg <= 1'b0;
			local_reg <= 1'b0;
			cnt_reg <= '0;
			hist_valid_reg <= 1'b0;
			hist_addr_reg <= '0;
			hist_fifo_reg <= 1'b0;
			elapsed_reg <= '0;
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (ce_in) begin
			// limitation: waits count enabled cycles only, so gating the enable can only lengthen them
			state_reg <= state_next;
			ready_reg <= ready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			oe_reg <= oe_next;
			last_reg <= last_next;
			local_reg <= local_next;
			cnt_reg <= cnt_next;
			hist_valid_reg <= hist_valid_next;
			hist_addr_reg <= hist_addr_next;
			hist_fifo_reg <= hist_fifo_next;
			elapsed_reg <= elapsed_next;
			sync1_reg <= dev_data_in;
			sync2_reg <= sync1_reg; // first stage read here only
		end
	end

	// pins come straight from registers, so no decode glitch reaches the device
	assign req_ready_out = ready_reg;
	assign rsp_valid_out = rvalid_reg;
	assign rsp_rdata_out = rdata_reg;
	assign dev_addr_out = addr_reg;
	assign dev_wr_out = wr_reg;
	assign dev_rd_out = rd_reg;
	assign dev_data_out = wdata_reg;
	assign dev_data_oe_out = oe_reg;

endmodule : wrg_guard
`default_nettype wire

// ### wrg_cfg.svh
`ifndef WRG_CFG_SVH
`define WRG_CFG_SVH

// device register map seen from the host bus
`define WRG_A_FIFO_LO 9'h000
`define WRG_A_FIFO_HI 9'h04C
`define WRG_A_IRQ_SETUP 9'h054
`define WRG_A_IRQ_FLAGS 9'h058
`define WRG_A_IRQ_MASK 9'h05C
`define WRG_A_PROBE 9'h064
`define WRG_A_FIFO_THR 9'h068
`define WRG_A_TX_FIFO_LEVEL 9'h080

// clock period and minimum write-to-read waits, in ns
`define WRG_CLK_NS 100
`define WRG_NS_ANY 45
`define WRG_NS_TXFIFO_LEVEL 135
`define WRG_NS_SETUP_SETUP 60
`define WRG_NS_MASK_SETUP 90
`define WRG_NS_MASK_FLAGS 60
`define WRG_NS_FLAGS_SETUP 180
`define WRG_NS_FLAGS_FLAGS 170
`define WRG_NS_THR_SETUP 90
`define WRG_NS_THR_FLAGS 80

// least time rounds up to whole cycles
`define WRG_CYC(ns) (((ns) + `WRG_CLK_NS - 1) / `WRG_CLK_NS)

// read strobe length: covers the two-stage data synchroniser
`define WRG_RD_HOLD_CYC 3
`define WRG_CNT_ZERO 0
`define WRG_ONE 1

`endif

// ### wrg_pkg.sv
package wrg_pkg;

	// one-hot access sequencer states
	typedef enum logic [3:0] {
		WRG_ST_IDLE = 4'b0001,
		WRG_ST_WRITE = 4'b0010,
		WRG_ST_HOLD = 4'b0100,
		WRG_ST_READ = 4'b1000
	} wrg_state_t;

endpackage : wrg_pkg

// ### wrg_wait_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrg_cfg.svh"

module wrg_wait_table #(
	parameter int ADDR_W = 9,
	parameter int CNT_W = 8
) (
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic wr_fifo_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [CNT_W-1:0] need_out
);

	// larger of two waits; several writes affect more than one read target
	function automatic logic [CNT_W-1:0] wrg_max(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		wrg_max = (a > b) ? a : b;
	endfunction : wrg_max

	localparam logic [CNT_W-1:0] C_ANY = CNT_W'(`WRG_CYC(`WRG_NS_ANY));
	localparam logic [CNT_W-1:0] C_TXL = CNT_W'(`WRG_CYC(`WRG_NS_TXFIFO_LEVEL));
	localparam logic [CNT_W-1:0] C_SS = CNT_W'(`WRG_CYC(`WRG_NS_SETUP_SETUP));
	localparam logic [CNT_W-1:0] C_MS = CNT_W'(`WRG_CYC(`WRG_NS_MASK_SETUP));
	localparam logic [CNT_W-1:0] C_MF = CNT_W'(`WRG_CYC(`WRG_NS_MASK_FLAGS));
	localparam logic [CNT_W-1:0] C_FS = CNT_W'(`WRG_CYC(`WRG_NS_FLAGS_SETUP));
	localparam logic [CNT_W-1:0] C_FF = CNT_W'(`WRG_CYC(`WRG_NS_FLAGS_FLAGS));
	localparam logic [CNT_W-1:0] C_TS = CNT_W'(`WRG_CYC(`WRG_NS_THR_SETUP));
	localparam logic [CNT_W-1:0] C_TF = CNT_W'(`WRG_CYC(`WRG_NS_THR_FLAGS));

	logic rd_setup;
	logic rd_flags;
	assign rd_setup = (rd_addr_in == ADDR_W'(`WRG_A_IRQ_SETUP));
	assign rd_flags = (rd_addr_in == ADDR_W'(`WRG_A_IRQ_FLAGS));

	// any read after a write except the probe waits the base time; the pair table can only lengthen it
	always_comb begin
		need_out = C_ANY;
		if (wr_fifo_in && rd_addr_in == ADDR_W'(`WRG_A_TX_FIFO_LEVEL)) begin
			need_out = wrg_max(need_out, C_TXL);
		end
		if (wr_addr_in == ADDR_W'(`WRG_A_IRQ_SETUP) && rd_setup) begin
			need_out = wrg_max(need_out, C_SS);
		end
		if (wr_addr_in == ADDR_W'(`WRG_A_IRQ_MASK)) begin
			if (rd_setup) need_out = wrg_max(need_out, C_MS);
			if (rd_flags) need_out = wrg_max(need_out, C_MF);
		end
		if (wr_addr_in == ADDR_W'(`WRG_A_IRQ_FLAGS)) begin
			if (rd_setup) need_out = wrg_max(need_out, C_FS);
			if (rd_flags) need_out = wrg_max(need_out, C_FF);
		end
		if (wr_addr_in == ADDR_W'(`WRG_A_FIFO_THR)) begin
			if (rd_setup) need_out = wrg_max(need_out, C_TS);
			if (rd_flags) need_out = wrg_max(need_out, C_TF);
		end
		// the probe register is the dummy read itself and never waits
		if (rd_addr_in == ADDR_W'(`WRG_A_PROBE)) begin
			need_out = CNT_W'(`WRG_CNT_ZERO);
		end
	end

endmodule : wrg_wait_table
`default_nettype wire

// ### wrg_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrg_cfg.svh"
// behavioural device behind the host bus: word store plus a read-only probe word
module wrg_dev_model #(
	parameter logic [31:0] PROBE_VAL = 32'h1357_9bdf // arbitrary probe pattern
) (
	input wire logic mclk_in,
	input wire logic [8:0] addr_in,
	input wire logic wr_in,
	input wire logic oe_in,
	input wire logic rd_in,
	input wire logic [31:0] wdata_in,
	output logic [31:0] rdata_out
);
	logic [31:0] store_reg [0:127];
	logic [31:0] last_reg = 32'h0000_0000;
	// words land on the write strobe; the probe word ignores writes
	always @(posedge mclk_in) begin
		if (wr_in && oe_in && addr_in != `WRG_A_PROBE) store_reg[addr_in[8:2]] <= wdata_in;
		if (rd_in) last_reg <= rdata_out;
	end
	initial for (int i = 0; i < 128; i++) store_reg[i] = 32'h0000_0000;
	// released lines show the inverse of the last word, so a late sample cannot match by luck
	always_comb rdata_out = !rd_in ? ~last_reg : (addr_in == `WRG_A_PROBE) ? PROBE_VAL : store_reg[addr_in[8:2]];
endmodule : wrg_dev_model
`default_nettype wire

// ### wrg_guard_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the access sequencer
module wrg_guard_properties #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 32
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic req_ready_out,
	input wire logic rsp_valid_out,
	input wire logic [DATA_W-1:0] rsp_rdata_out,
	input wire logic [ADDR_W-1:0] dev_addr_out,
	input wire logic dev_wr_out,
	input wire logic dev_rd_out,
	input wire logic dev_data_oe_out,
	input wire logic [DATA_W-1:0] dev_data_in
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// a taken request; ready is only ever high while idle
	wire logic take = ce_in && req_valid_in && req_ready_out;
	AST_WR_PULSE: assert property (dev_wr_out |=> !dev_wr_out) else $error("write strobe too long");
	AST_OE_WR: assert property (dev_data_oe_out == dev_wr_out) else $error("data enable off strobe");
	AST_WR_ADDR: assert property (take && req_write_in |=> dev_wr_out && dev_addr_out == $past(req_addr_in))
		else $error("write not launched");
	AST_RD_LEN: assert property ($rose(dev_rd_out) |-> dev_rd_out[*3] ##1 !dev_rd_out) else $error("read strobe length");
	AST_RSP_DATA: assert property ($fell(dev_rd_out) |-> rsp_valid_out && rsp_rdata_out == $past(dev_data_in, 3))
		else $error("read data not from first strobe cycle");
	AST_WAIT: assert property ($fell(dev_wr_out) |-> !dev_rd_out[*2]) else $error("read too soon after write");
	AST_RD_BOUND: assert property (take && !req_write_in |-> ##[4:9] rsp_valid_out) else $error("read answer late");
	AST_BUSY: assert property (dev_rd_out || dev_wr_out |-> !req_ready_out) else $error("ready while busy");
	AST_RSP_PULSE: assert property (rsp_valid_out |=> !rsp_valid_out) else $error("response pulse too long");
	COV_WR: cover property (take && req_write_in);
	COV_RD: cover property ($rose(dev_rd_out));
	COV_WR_RD: cover property ($fell(dev_wr_out) ##3 dev_rd_out);
endmodule : wrg_guard_properties
bind wrg_guard wrg_guard_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_wrg_guard_properties (
	.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
	.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_ready_out(req_ready_out),
	.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .dev_addr_out(dev_addr_out),
	.dev_wr_out(dev_wr_out), .dev_rd_out(dev_rd_out), .dev_data_oe_out(dev_data_oe_out), .dev_data_in(dev_data_in));
`default_nettype wire

// ### write_read_spacing_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none
module write_read_spacing_guard_tb;
	localparam logic [31:0] PROBE = 32'h1357_9bdf; // arbitrary probe pattern
	logic mclk_in = 0, rst_b_in = 0, ce_in = 1, req_valid_in = 0, req_write_in = 0, req_last_in = 0, req_local_in = 0;
	logic [8:0] req_addr_in = 9'h000, dev_addr_out, wr_a;
	logic [31:0] req_wdata_in = 32'h0000_0000, rsp_rdata_out, dev_data_out, dev_data_in, seed = 32'h5f91, exp_mem [0:127];
	logic req_ready_out, rsp_valid_out, dev_wr_out, dev_rd_out, dev_data_oe_out, have_wr = 0, rd_prev = 0;
	int bad_count = 0, checks_done = 0, cyc = 0, wr_cyc = 0, el = 0, el_prev = 0, tk_cyc = 0, n_cyc = 0;
	logic [8:0] tab [0:8] = '{9'h000, 9'h04C, 9'h054, 9'h058, 9'h05C, 9'h064, 9'h068, 9'h080, 9'h070};
	always #50 mclk_in = ~mclk_in;
	wrg_guard u_wrg_guard (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
		.req_write_in(req_write_in), .req_last_in(req_last_in), .req_local_in(req_local_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_rdata_out(rsp_rdata_out), .dev_addr_out(dev_addr_out), .dev_wr_out(dev_wr_out), .dev_rd_out(dev_rd_out),
		.dev_data_out(dev_data_out), .dev_data_oe_out(dev_data_oe_out), .dev_data_in(dev_data_in));
	wrg_dev_model #(.PROBE_VAL(PROBE)) u_wrg_dev_model (.mclk_in(mclk_in), .addr_in(dev_addr_out), .wr_in(dev_wr_out),
		.oe_in(dev_data_oe_out), .rd_in(dev_rd_out), .wdata_in(dev_data_out), .rdata_out(dev_data_in));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// least wait in ns for a read after a word-completing write
	function automatic int need_ns(input logic [8:0] wa, input logic [8:0] ra);
		if (ra == 9'h064) return 0;
		if (wa <= 9'h04C && ra == 9'h080) return 135;
		case ({wa, ra})
			{9'h054, 9'h054}: return 60;
			{9'h05C, 9'h054}, {9'h068, 9'h054}: return 90;
			{9'h05C, 9'h058}: return 60;
			{9'h068, 9'h058}: return 80;
			{9'h058, 9'h054}: return 180;
			{9'h058, 9'h058}: return 170;
			default: return 45;
		endcase
	endfunction : need_ns
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	// one request; optional idle stretch with the clock enable low, which stretches the wait
	task automatic op(input logic w, input logic [8:0] a, input logic [31:0] d, input logic last, loc, idle);
		if (idle) begin
			ce_in <= 0;
			repeat (2) @(posedge mclk_in);
			ce_in <= 1;
		end
		req_valid_in <= 1;
		req_write_in <= w;
		req_addr_in <= a;
		req_wdata_in <= d;
		req_last_in <= last | !w;
		req_local_in <= loc;
		do @(posedge mclk_in); while (!req_ready_out || !ce_in);
		req_valid_in <= 0;
		if (!w) begin
			do @(posedge mclk_in); while (!rsp_valid_out);
			check("read data", a == 9'h064 ? PROBE : exp_mem[a[8:2]], rsp_rdata_out);
		end else if (a != 9'h064) exp_mem[a[8:2]] = d;
		@(posedge mclk_in); // one edge between requests, so a read can follow a write closely
	endtask : op
	// pin monitor: elapsed time from the last word-completing write to each read strobe
	always @(posedge mclk_in) begin
		cyc++;
		// a read is judged against the write count as it stood when its strobe was launched
		if (dev_rd_out && !rd_prev && have_wr && !req_local_in) begin
			n_cyc = (need_ns(wr_a, dev_addr_out) + 99) / 100; // least wait in whole 100 ns cycles
			check("read spacing", 1, 32'((cyc - wr_cyc - 1) * 100 >= need_ns(wr_a, dev_addr_out)));
			check("read wait", 1, 32'(el_prev >= n_cyc && (cyc == tk_cyc + 2 || el_prev == n_cyc)));
		end
		if (req_valid_in && req_ready_out && ce_in && !req_write_in) tk_cyc = cyc;
		el_prev = el;
		if (dev_wr_out && req_last_in && !req_local_in) begin
			wr_cyc = cyc;
			wr_a = dev_addr_out;
			have_wr = rst_b_in;
			el = 0;
		end else if (ce_in && el < 255) begin
			el++; // enabled cycles only, a frozen guard does not count
		end
		if (!rst_b_in) have_wr = 0;
		rd_prev = dev_rd_out;
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		report_and_stop();
	end
	initial begin
		for (int i = 0; i < 128; i++) exp_mem[i] = 32'h0000_0000;
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1;
		check("idle after reset", 32'h0000_0001, {31'h0000_0000, req_ready_out});
		check("strobes after reset", 32'h0000_0000, {29'h0000_0000, dev_wr_out, dev_rd_out, rsp_valid_out});
		for (int i = 0; i < 400; i++) begin
			seed = xs(seed);
			if (i == 200) begin
				rst_b_in <= 0;
				have_wr = 0;
				repeat (2) @(posedge mclk_in);
				rst_b_in <= 1;
				check("idle after reset", 32'h0000_0001, {31'h0000_0000, req_ready_out});
				check("strobes after reset", 32'h0000_0000, {29'h0000_0000, dev_wr_out, dev_rd_out, rsp_valid_out});
			end
			op(seed[0], tab[seed[11:8] % 9], xs(seed), seed[1] | seed[2], seed[3] & seed[4] & seed[5], seed[6] & seed[7]);
		end
		report_and_stop();
	end
endmodule : write_read_spacing_guard_tb
`default_nettype wire
